// file: core/vertical_blank_pulse_pkg.sv
/*
  Constants and types for the vertical blanking pulse timer.
  Assumes a single 40 MHz clock and a synchronous active-high reset.
*/
package vertical_blank_pulse_pkg;

  // Register map, two-byte register pointer on the serial port
  localparam logic [15:0] VERTICAL_BLANK_PULSE_LEN_ADDR  = 16'h8403;
  localparam logic [7:0]  VERTICAL_BLANK_PULSE_LEN_RESET = 8'h10;
  // Serial slave address, value arbitrary
  localparam logic [6:0]  SLAVE_ADDR       = 7'h2A;
  localparam logic [7:0]  READ_MISS_DATA   = 8'h00;

  // Clock
  localparam int CLOCK_HZ  = 40_000_000;
  localparam int CLOCK_MHZ = CLOCK_HZ / 1_000_000;

  // Horizontal flyback loss and free-run horizontal blanking
  localparam int H_LOSS_US        = 100;
  localparam int H_LOSS_CYC       = H_LOSS_US * CLOCK_MHZ;
  localparam int H_FREE_KHZ       = 45;
  localparam int H_FREE_CYC       = CLOCK_HZ / (H_FREE_KHZ * 1000);
  localparam int H_FREE_WIDTH_NS  = 2000;
  localparam int H_FREE_W_CYC     = (H_FREE_WIDTH_NS * CLOCK_MHZ + 999) / 1000;
  localparam int H_CNT_W          = 12;

  // Vertical flyback loss and free-run vertical trigger
  localparam int V_LOSS_MS        = 50;
  localparam int V_LOSS_CYC_DEF   = V_LOSS_MS * CLOCK_HZ / 1000;
  localparam int V_FREE_HZ        = 60;
  localparam int V_FREE_CYC_DEF   = CLOCK_HZ / V_FREE_HZ;
  localparam int V_FREE_W_CYC     = 2 * H_FREE_CYC;
  localparam int V_CNT_W          = 24;

  // Blank timer states
  typedef enum logic [1:0] {
    VB_IDLE   = 2'b01,
    VB_TIMING = 2'b10
  } vb_state_t;

  // Serial slave states
  typedef enum logic [4:0] {
    SL_IDLE  = 5'b00001,
    SL_RX    = 5'b00010,
    SL_ACK   = 5'b00100,
    SL_TX    = 5'b01000,
    SL_TXACK = 5'b10000
  } sl_state_t;

endpackage

// file: core/vertical_blank_pulse_timer.sv
/*
  Vertical blanking pulse timer with horizontal blanking derivation,
  flyback loss handling and a small serial register slave.
  Assumes flyback inputs and serial lines are asynchronous pins.
*/
`timescale 1ns/100ps

// Summary of operation
// - Negative blank pulse once per vertical period
// - Pulse length follows written duration register
// - Only rising vertical trigger edge acts
// - Trigger starts line counter on horizontal blanks
// - Reaching written target ends the pulse
// - Trigger edges ignored while blank active
// - Blank output is trigger OR timing state
// - Derive horizontal blank from horizontal flyback
// - Horizontal loss: free-run blanks, mute video
// - Vertical loss: free-run blanks, mute video
module vertical_blank_pulse_timer
#(
  parameter int V_LOSS_CYC = vertical_blank_pulse_pkg::V_LOSS_CYC_DEF,
  parameter int V_FREE_CYC = vertical_blank_pulse_pkg::V_FREE_CYC_DEF
)
(
  // Clock and reset
  input  wire logic CLOCK,
  input  wire logic RST,
  // Serial register port
  input  wire logic SCL_IN,
  input  wire logic SDA_IN,
  output logic      SDA_OUT,
  output logic      SDA_OE,
  // Deflection side
  input  wire logic HORIZONTAL_RETRACE_INPUT,
  input  wire logic VERTICAL_RETRACE_INPUT,
  // Driver side
  output logic      VERTICAL_BLANK_PULSE_N,
  output logic      HORIZONTAL_BLANK_PULSE,
  output logic      VIDEO_MUTE
);
  import vertical_blank_pulse_pkg::*;

  // Two-stage synchronisers: bit 0 SCL, 1 SDA, 2 H flyback, 3 V flyback
  logic [3:0] meta_r;
  logic [3:0] sync_r;
  logic [3:0] prev_r;

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      meta_r <= 4'h3;
      sync_r <= 4'h3;
      prev_r <= 4'h3;
    end
    else
    begin
      meta_r <= {VERTICAL_RETRACE_INPUT, HORIZONTAL_RETRACE_INPUT, SDA_IN, SCL_IN};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic i2c_start;
  logic i2c_stop;
  logic hfly_rise;
  logic vfly_rise;

  assign sda_s     = sync_r[1];
  assign scl_rise  = sync_r[0] & ~prev_r[0];
  assign scl_fall  = ~sync_r[0] & prev_r[0];
  assign i2c_start = sync_r[0] & prev_r[0] & ~sda_s & prev_r[1];
  assign i2c_stop  = sync_r[0] & prev_r[0] & sda_s & ~prev_r[1];
  assign hfly_rise = sync_r[2] & ~prev_r[2];
  assign vfly_rise = sync_r[3] & ~prev_r[3];

  // Horizontal blanking and its loss detector
  logic [H_CNT_W-1:0] h_gap_r, h_gap_nxt;
  logic [H_CNT_W-1:0] h_free_r, h_free_nxt;
  logic               h_lost_r, h_lost_nxt;
  logic               horizontal_blank_pulse_r, horizontal_blank_pulse_nxt;
  logic               horizontal_blank_pulse_prev_r;

  always_comb
  begin
    h_gap_nxt  = h_gap_r;
    h_lost_nxt = h_lost_r;
    if (hfly_rise)
    begin
      h_gap_nxt  = '0;
      h_lost_nxt = 1'b0;
    end
    else if (h_gap_r >= H_CNT_W'(H_LOSS_CYC - 1))
      h_lost_nxt = 1'b1;
    else
      h_gap_nxt = h_gap_r + 1'b1;
    h_free_nxt = (h_free_r == H_CNT_W'(H_FREE_CYC - 1)) ? '0 : h_free_r + 1'b1;
    // Free-run keeps the driver biased when the scan stops
    horizontal_blank_pulse_nxt = h_lost_r ? (h_free_r < H_CNT_W'(H_FREE_W_CYC)) : sync_r[2];
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      h_gap_r       <= '0;
      h_free_r      <= '0;
      h_lost_r      <= 1'b0;
      horizontal_blank_pulse_r      <= 1'b0;
      horizontal_blank_pulse_prev_r <= 1'b0;
    end
    else
    begin
      h_gap_r       <= h_gap_nxt;
      h_free_r      <= h_free_nxt;
      h_lost_r      <= h_lost_nxt;
      horizontal_blank_pulse_r      <= horizontal_blank_pulse_nxt;
      horizontal_blank_pulse_prev_r <= horizontal_blank_pulse_r;
    end
  end

  // Vertical loss detector and free-run trigger
  logic [V_CNT_W-1:0] v_gap_r, v_gap_nxt;
  logic [V_CNT_W-1:0] v_free_r, v_free_nxt;
  logic               v_lost_r, v_lost_nxt;
  logic               vtrig;

  always_comb
  begin
    v_gap_nxt  = v_gap_r;
    v_lost_nxt = v_lost_r;
    if (vfly_rise)
    begin
      v_gap_nxt  = '0;
      v_lost_nxt = 1'b0;
    end
    else if (v_gap_r >= V_CNT_W'(V_LOSS_CYC - 1))
      v_lost_nxt = 1'b1;
    else
      v_gap_nxt = v_gap_r + 1'b1;
    v_free_nxt = (v_free_r == V_CNT_W'(V_FREE_CYC - 1)) ? '0 : v_free_r + 1'b1;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      v_gap_r  <= '0;
      v_free_r <= '0;
      v_lost_r <= 1'b0;
    end
    else
    begin
      v_gap_r  <= v_gap_nxt;
      v_free_r <= v_free_nxt;
      v_lost_r <= v_lost_nxt;
    end
  end

  // Free-run trigger is two lines wide so it outlasts the timer start
  assign vtrig = v_lost_r ? (v_free_r < V_CNT_W'(V_FREE_W_CYC)) : sync_r[3];

  // Blank timer
  vb_state_t  vb_state_r, vb_state_nxt;
  logic [7:0] line_cnt_r, line_cnt_nxt;
  logic [7:0] len_r, len_nxt;
  logic       vtrig_prev_r;
  logic       blank_r, blank_nxt;
  logic       mute_r;
  logic       trig_go;
  logic       h_tick;
  logic       line_done;

  assign h_tick    = horizontal_blank_pulse_r & ~horizontal_blank_pulse_prev_r;
  // Gating with the live blank keeps a noisy flyback from retriggering
  assign trig_go   = vtrig & ~vtrig_prev_r & ~blank_r;
  assign line_done = (9'(line_cnt_r) + 9'd1) >= 9'(len_r);

  always_comb
  begin
    vb_state_nxt = vb_state_r;
    line_cnt_nxt = line_cnt_r;
    unique case (vb_state_r)
      VB_IDLE:
      begin
        line_cnt_nxt = '0;
        if (trig_go)
          vb_state_nxt = VB_TIMING;
      end
      VB_TIMING:
      begin
        if (h_tick)
        begin
          if (line_done)
          begin
            vb_state_nxt = VB_IDLE;
            line_cnt_nxt = '0;
          end
          else
            line_cnt_nxt = line_cnt_r + 1'b1;
        end
      end
    endcase
    blank_nxt = vtrig | (vb_state_nxt == VB_TIMING);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      vb_state_r   <= VB_IDLE;
      line_cnt_r   <= '0;
      vtrig_prev_r <= 1'b0;
      blank_r      <= 1'b0;
      mute_r       <= 1'b0;
    end
    else
    begin
      vb_state_r   <= vb_state_nxt;
      line_cnt_r   <= line_cnt_nxt;
      vtrig_prev_r <= vtrig;
      blank_r      <= blank_nxt;
      mute_r       <= h_lost_r | v_lost_r;
    end
  end

  assign VERTICAL_BLANK_PULSE_N = ~blank_r;
  assign HORIZONTAL_BLANK_PULSE = horizontal_blank_pulse_r;
  assign VIDEO_MUTE             = mute_r;

  // Serial register slave: address byte, two pointer bytes, then data
  sl_state_t   sl_r, sl_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic [3:0]  bit_r, bit_nxt;
  logic [1:0]  byte_r, byte_nxt;
  logic [15:0] ptr_r, ptr_nxt;
  logic        rw_r, rw_nxt;
  logic        nack_r, nack_nxt;
  logic        oe_r, oe_nxt;
  logic        wr_en;
  logic [7:0]  rd_data;

  assign rd_data = (ptr_r == VERTICAL_BLANK_PULSE_LEN_ADDR) ? len_r : READ_MISS_DATA;

  always_comb
  begin
    sl_nxt   = sl_r;
    sh_nxt   = sh_r;
    bit_nxt  = bit_r;
    byte_nxt = byte_r;
    ptr_nxt  = ptr_r;
    rw_nxt   = rw_r;
    nack_nxt = nack_r;
    oe_nxt   = oe_r;
    wr_en    = 1'b0;
    if (i2c_start)
    begin
      sl_nxt   = SL_RX;
      bit_nxt  = '0;
      byte_nxt = '0;
      oe_nxt   = 1'b0;
    end
    else if (i2c_stop)
    begin
      sl_nxt = SL_IDLE;
      oe_nxt = 1'b0;
    end
    else
    begin
      unique case (sl_r)
        SL_IDLE: ;
        SL_RX:
        begin
          if (scl_rise)
          begin
            sh_nxt  = {sh_r[6:0], sda_s};
            bit_nxt = bit_r + 1'b1;
          end
          else if (scl_fall && bit_r == 4'h8)
          begin
            sl_nxt = SL_ACK;
            oe_nxt = 1'b1;
            if (byte_r != 2'h3)
              byte_nxt = byte_r + 1'b1;
            unique case (byte_r)
              2'h0:
              begin
                rw_nxt = sh_r[0];
                if (sh_r[7:1] != SLAVE_ADDR)
                begin
                  sl_nxt = SL_IDLE;
                  oe_nxt = 1'b0;
                end
              end
              2'h1: ptr_nxt[15:8] = sh_r;
              2'h2: ptr_nxt[7:0] = sh_r;
              2'h3:
              begin
                wr_en   = (ptr_r == VERTICAL_BLANK_PULSE_LEN_ADDR);
                ptr_nxt = ptr_r + 1'b1;
              end
            endcase
          end
        end
        SL_ACK:
        begin
          if (scl_fall)
          begin
            bit_nxt = '0;
            if (rw_r && byte_r == 2'h1)
            begin
              sl_nxt = SL_TX;
              sh_nxt = rd_data;
              oe_nxt = ~rd_data[7];
            end
            else
            begin
              sl_nxt = SL_RX;
              oe_nxt = 1'b0;
            end
          end
        end
        SL_TX:
        begin
          if (scl_fall)
          begin
            if (bit_r == 4'h7)
            begin
              sl_nxt  = SL_TXACK;
              oe_nxt  = 1'b0;
              ptr_nxt = ptr_r + 1'b1;
            end
            else
            begin
              bit_nxt = bit_r + 1'b1;
              sh_nxt  = {sh_r[6:0], 1'b0};
              oe_nxt  = ~sh_r[6];
            end
          end
        end
        SL_TXACK:
        begin
          if (scl_rise)
            nack_nxt = sda_s;
          else if (scl_fall)
          begin
            bit_nxt = '0;
            sl_nxt  = nack_r ? SL_IDLE : SL_TX;
            sh_nxt  = rd_data;
            oe_nxt  = ~nack_r & ~rd_data[7];
          end
        end
      endcase
    end
    len_nxt = wr_en ? sh_r : len_r;
  end

  always_ff @(posedge CLOCK)
  begin
    if (RST)
    begin
      sl_r   <= SL_IDLE;
      sh_r   <= '0;
      bit_r  <= '0;
      byte_r <= '0;
      ptr_r  <= '0;
      rw_r   <= 1'b0;
      nack_r <= 1'b0;
      oe_r   <= 1'b0;
      len_r  <= VERTICAL_BLANK_PULSE_LEN_RESET;
    end
    else
    begin
      sl_r   <= sl_nxt;
      sh_r   <= sh_nxt;
      bit_r  <= bit_nxt;
      byte_r <= byte_nxt;
      ptr_r  <= ptr_nxt;
      rw_r   <= rw_nxt;
      nack_r <= nack_nxt;
      oe_r   <= oe_nxt;
      len_r  <= len_nxt;
    end
  end

  // Open-drain data line only ever pulls low
  assign SDA_OUT = 1'b0;
  assign SDA_OE  = oe_r;

  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  blank_or_a:   assert property (vtrig |=> blank_r) else $error("trigger not passed to blank");
  out_neg_a:    assert property (VERTICAL_BLANK_PULSE_N == !blank_r) else $error("blank output not inverted");
  start_cnt_a:  assert property (vb_state_r == VB_IDLE && trig_go |=>
                  vb_state_r == VB_TIMING && line_cnt_r == 8'h00) else $error("timer did not start");
  no_retrig_a:  assert property (vb_state_r == VB_TIMING && !h_tick |=>
                  vb_state_r == VB_TIMING && $stable(line_cnt_r)) else $error("timer disturbed between lines");
  line_step_a:  assert property (vb_state_r == VB_TIMING && h_tick && !line_done |=>
                  line_cnt_r == $past(line_cnt_r) + 8'h01) else $error("line count did not step");
  pulse_end_a:  assert property (vb_state_r == VB_TIMING && h_tick && line_done |=>
                  vb_state_r == VB_IDLE && line_cnt_r == 8'h00) else $error("pulse did not end at target");
  fall_edge_a:  assert property (vb_state_r == VB_IDLE && !vtrig && $past(vtrig) |=>
                  vb_state_r == VB_IDLE && !blank_r) else $error("falling edge kept blank or started timer");
  mute_loss_a:  assert property (h_lost_r || v_lost_r |=> VIDEO_MUTE) else $error("mute missing on loss");
  hfree_run_a:  assert property (h_lost_r && h_free_r == 12'h000 |=>
                  HORIZONTAL_BLANK_PULSE) else $error("no free-run horizontal blank");
  reg_write_a:  assert property (wr_en |=> len_r == $past(sh_r)) else $error("duration write lost");

  pulse_cov_c:  cover property (vb_state_r == VB_TIMING && h_tick && line_done);
  hloss_cov_c:  cover property ($rose(h_lost_r));
  vloss_cov_c:  cover property ($rose(v_lost_r));
  write_cov_c:  cover property (wr_en);

endmodule

// file: verif/deflection_model.sv
/*
  Deflection side model: horizontal and vertical flyback pins.
  Assumes the bench clock; requests arrive on rising edges.
*/
`timescale 1ns/100ps
module deflection_model
#(
  parameter int H_PER  = 400,
  parameter int H_HIGH = 60
)
(
  // Clock
  input  wire logic       clk,
  // Requests from the bench
  input  wire logic       h_on,
  input  wire logic       v_go,
  input  wire logic [3:0] v_lines,
  // Flyback pins
  output logic            h_fly,
  output logic            v_fly
);
  int         hc   = 0;
  logic       pend = 1'b0;
  logic [3:0] left = 4'h0;

  initial
  begin
    h_fly = 1'b0;
    v_fly = 1'b0;
  end

  always @(posedge clk)
  begin
    hc    <= (hc == H_PER - 1) ? 0 : hc + 1;
    h_fly <= h_on && (hc < H_HIGH);
    if (v_go)
      pend <= 1'b1;
    // Edges sit mid-line, so a held pulse always spans a line start
    if (hc == H_PER / 2)
    begin
      if (pend)
      begin
        v_fly <= 1'b1;
        left  <= v_lines;
        pend  <= 1'b0;
      end
      else if (left > 4'h1)
        left <= left - 4'h1;
      else
        v_fly <= 1'b0;
    end
  end
endmodule

// file: verif/vertical_blank_pulse_timer_tb_top.sv
/*
  Bench: serial register access, blank width, gating and flyback loss.
  Assumes the deflection model drives both flyback pins.
*/
`timescale 1ns/100ps
module vertical_blank_pulse_timer_tb_top;
  import vertical_blank_pulse_pkg::*;
  localparam int H_PER  = 400;
  localparam int V_FREE = 30000;
  logic       clock   = 1'b0;
  logic       rst     = 1'b1;
  logic       scl     = 1'b1;
  logic       m_low   = 1'b0;
  logic       h_on    = 1'b1;
  logic       v_go    = 1'b0;
  logic [3:0] v_lines = 4'h1;
  logic       h_fly, v_fly, sda_oe, sda_out, blank_n, horizontal_blank_pulse, mute, hp;
  logic       ack_seen;
  logic [7:0] q;
  logic [7:0] lens [3] = '{8'h01, 8'h03, 8'h06};
  // Pull-up on the data line
  wire        sda = (sda_oe ? sda_out : 1'b1) & ~m_low;
  int         mismatches = 0;
  int         samples_checked = 0;
  int         cycles = 0;
  int         n, lat, lines, relow;

  deflection_model #(.H_PER(H_PER), .H_HIGH(60)) flyback (.clk(clock), .h_on(h_on), .v_go(v_go),
    .v_lines(v_lines), .h_fly(h_fly), .v_fly(v_fly));
  vertical_blank_pulse_timer #(.V_LOSS_CYC(20000), .V_FREE_CYC(V_FREE)) dut (.CLOCK(clock), .RST(rst), .SCL_IN(scl),
    .SDA_IN(sda), .SDA_OUT(sda_out), .SDA_OE(sda_oe), .HORIZONTAL_RETRACE_INPUT(h_fly),
    .VERTICAL_RETRACE_INPUT(v_fly), .VERTICAL_BLANK_PULSE_N(blank_n), .HORIZONTAL_BLANK_PULSE(horizontal_blank_pulse),
    .VIDEO_MUTE(mute));

  initial
    forever #12.5 clock = ~clock;

  task automatic end_sim;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 90000)
    begin
      mismatches++;
      end_sim;
    end
  end

  task automatic tick(input int k);
    repeat (k) @(posedge clock);
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // Slow serial phases keep well clear of the input synchronisers
  task automatic bitx(input logic b, output logic r);
    m_low <= ~b;
    tick(10);
    scl <= 1'b1;
    tick(5);
    @(negedge clock);
    r = sda;
    tick(5);
    scl <= 1'b0;
    tick(10);
  endtask

  task automatic xbyte(input logic [7:0] d, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      bitx(d[i], r[i]);
    bitx(1'b1, ack);
  endtask

  task automatic start;
    m_low <= 1'b0;
    tick(10);
    scl <= 1'b1;
    tick(10);
    m_low <= 1'b1;
    tick(10);
    scl <= 1'b0;
    tick(10);
  endtask

  task automatic stop;
    m_low <= 1'b1;
    tick(10);
    scl <= 1'b1;
    tick(10);
    m_low <= 1'b0;
    tick(10);
  endtask

  task automatic point(input logic [15:0] a);
    logic [7:0] r;
    logic       ack;
    start;
    xbyte({SLAVE_ADDR, 1'b0}, r, ack);
    chk("addr ack", 16'(ack), 16'h0);
    xbyte(a[15:8], r, ack);
    xbyte(a[7:0], r, ack);
    chk("ptr ack", 16'(ack), 16'h0);
  endtask

  task automatic reg_write(input logic [15:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic       ack;
    point(a);
    xbyte(d, r, ack);
    stop;
  endtask

  task automatic reg_read(input logic [15:0] a, output logic [7:0] d);
    logic ack;
    point(a);
    start;
    xbyte({SLAVE_ADDR, 1'b1}, d, ack);
    xbyte(8'hFF, d, ack);
    stop;
  endtask

  // Counts horizontal_blank_pulse rises, or blank falls when sel is set
  task automatic count(input int k, input logic sel);
    lines = 0;
    hp = sel ? ~blank_n : horizontal_blank_pulse;
    repeat (k)
    begin
      @(negedge clock);
      if ((sel ? ~blank_n : horizontal_blank_pulse) === 1'b1 && hp !== 1'b1)
        lines++;
      hp = sel ? ~blank_n : horizontal_blank_pulse;
    end
  endtask

  task automatic vpulse(input logic [3:0] hold);
    v_lines <= hold;
    v_go <= 1'b1;
    tick(1);
    v_go <= 1'b0;
    for (n = 0; n < 2 * H_PER && v_fly !== 1'b1; n++)
      @(negedge clock);
    for (lat = 0; lat < 10 && blank_n !== 1'b0; lat++)
      @(negedge clock);
    lines = 0;
    hp = horizontal_blank_pulse;
    for (n = 0; n < 20 * H_PER && blank_n === 1'b0; n++)
    begin
      @(negedge clock);
      if (horizontal_blank_pulse === 1'b1 && hp !== 1'b1 && blank_n === 1'b0)
        lines++;
      hp = horizontal_blank_pulse;
    end
    relow = 0;
    repeat (3 * H_PER)
    begin
      @(negedge clock);
      if (blank_n !== 1'b1)
        relow++;
    end
    tick(1);
  endtask

  initial
  begin
    tick(5);
    rst <= 1'b0;
    tick(2);
    @(negedge clock);
    chk("blank idle", 16'(blank_n), 16'h1);
    chk("mute idle", 16'(mute), 16'h0);
    reg_read(VERTICAL_BLANK_PULSE_LEN_ADDR, q);
    chk("length reset", 16'(q), 16'(VERTICAL_BLANK_PULSE_LEN_RESET));
    foreach (lens[i])
    begin
      reg_write(VERTICAL_BLANK_PULSE_LEN_ADDR, lens[i]);
      vpulse(4'h1);
      chk("blank latency", 16'(lat), 16'h3);
      chk("blank lines", 16'(lines), 16'(lens[i]));
      chk("quiet after end", 16'(relow), 16'h0);
    end
    // Second flyback lands mid-pulse; the first has already fallen
    fork
      vpulse(4'h1);
      begin
        tick(3 * H_PER);
        v_go <= 1'b1;
        tick(1);
        v_go <= 1'b0;
      end
    join
    chk("retrigger gated", 16'(lines), 16'h6);
    reg_write(16'h8400, 8'h77);
    reg_read(16'h8400, q);
    chk("unmapped read", 16'(q), 16'(READ_MISS_DATA));
    reg_read(VERTICAL_BLANK_PULSE_LEN_ADDR, q);
    chk("length kept", 16'(q), 16'h0006);
    // A foreign address must be left unanswered
    start;
    xbyte({~SLAVE_ADDR, 1'b0}, q, ack_seen);
    stop;
    chk("foreign addr nack", 16'(ack_seen), 16'h1);
    // Two-byte write from the unmapped word below lands the second byte in the length
    point(16'h8402);
    xbyte(8'h05, q, ack_seen);
    xbyte(8'h02, q, ack_seen);
    stop;
    // Master acknowledge continues the read at the next pointer
    point(16'h8402);
    start;
    xbyte({SLAVE_ADDR, 1'b1}, q, ack_seen);
    for (int i = 7; i >= 0; i--)
      bitx(1'b1, q[i]);
    bitx(1'b0, ack_seen);
    chk("burst first", 16'(q), 16'(READ_MISS_DATA));
    xbyte(8'hFF, q, ack_seen);
    stop;
    chk("burst length", 16'(q), 16'h0002);
    @(posedge h_fly);
    tick(3);
    @(negedge clock);
    chk("horizontal_blank_pulse follows", 16'(horizontal_blank_pulse), 16'h1);
    tick(1);
    v_go <= 1'b1;
    h_on <= 1'b0;
    tick(1);
    v_go <= 1'b0;
    tick(4200);
    @(negedge clock);
    chk("mute on h loss", 16'(mute), 16'h1);
    count(3 * H_FREE_CYC, 1'b0);
    chk("free horizontal_blank_pulse", 16'(lines), 16'h3);
    tick(1);
    h_on <= 1'b1;
    tick(2 * H_PER);
    @(negedge clock);
    chk("mute clears", 16'(mute), 16'h0);
    tick(13500);
    @(negedge clock);
    chk("mute on v loss", 16'(mute), 16'h1);
    count(V_FREE, 1'b1);
    chk("free vertical_blank_pulse", 16'(lines), 16'h1);
    end_sim;
  end
endmodule
